//--- bench/adc_core_model.sv
// Behavioural analog core: converts a given code after a fixed delay
`timescale 1ns/1ps
`default_nettype none
module adc_core_model #(
    parameter int CONV_CYCLES = 8
) (
    input wire logic pclk, // Clock
    input wire logic presetn, // Reset
    input wire logic start, // Start pulse
    input wire logic [9:0] code, // Code to deliver
    output logic conv_busy, // Converting
    output logic conv_done, // One-cycle done
    output logic [9:0] conv_value // Result, valid with done only
);
    logic [7:0] cnt;
    logic [9:0] held;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt <= 8'h0;
            held <= 10'h0;
            conv_busy <= 1'b0;
            conv_done <= 1'b0;
            conv_value <= 10'h0;
        end else begin
            conv_done <= 1'b0;
            // Outside the done cycle the value toggles so stale data is never trusted
            conv_value <= ~conv_value;
            if (start && !conv_busy) begin
                conv_busy <= 1'b1;
                cnt <= 8'(CONV_CYCLES);
                held <= code;
            end else if (conv_busy && cnt == 8'h1) begin
                conv_busy <= 1'b0;
                conv_done <= 1'b1;
                conv_value <= held;
            end else if (conv_busy) begin
                cnt <= cnt - 8'h1;
            end
        end
    end
endmodule // adc_core_model
`default_nettype wire

//--- bench/adc_fmt_assertions.sv
// Port-level checker for the result format and input select block
`timescale 1ns/1ps
`default_nettype none
module adc_fmt_checker
    import adc_fmt_pkg::*;
(
    input wire logic pclk, // Clock
    input wire logic presetn, // Reset
    input wire logic psel, // Select
    input wire logic penable, // Enable
    input wire logic pwrite, // Direction
    input wire logic [adc_fmt_pkg::ADDR_W-1:0] paddr, // Address
    input wire logic [31:0] prdata, // Read data
    input wire logic pready, // Ready
    input wire logic pslverr, // Error
    input wire logic conv_busy, // Core busy
    input wire logic conv_done, // Core done
    input wire logic [1:0] active_ref_select, // Applied reference
    input wire logic [3:0] active_channel, // Applied channel
    input wire logic external_reference_pin_en, // Pin path
    input wire logic analog_supply_reference_en, // Supply path
    input wire logic internal_ref_power // Internal power
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence bad_setup;
        psel && !penable && paddr > 12'h018;
    endsequence
    sequence access_phase;
        psel && penable;
    endsequence
    a_ready_high: assert property (pready) else $error("pready low");
    a_err_unmapped: assert property (bad_setup ##1 access_phase |-> pslverr)
        else $error("no error on unmapped access");
    a_err_read_zero: assert property (bad_setup ##1 (access_phase and !pwrite) |-> prdata == 32'h0)
        else $error("unmapped read not zero");
    a_pin_ref_en: assert property (external_reference_pin_en == (active_ref_select == 2'b00))
        else $error("pin reference path wrong");
    a_supply_ref_en: assert property (analog_supply_reference_en == (active_ref_select == 2'b01))
        else $error("supply reference path wrong");
    a_int_ref_power: assert property (internal_ref_power |-> active_ref_select == 2'b11)
        else $error("internal reference powered when not selected");
    a_ref_wait_done: assert property (conv_busy && !conv_done |=> $stable(active_ref_select))
        else $error("reference changed mid conversion");
    a_active_hold: assert property (!conv_done && !(psel && penable && pwrite) |=> $stable(active_channel))
        else $error("channel changed without cause");
endmodule // adc_fmt_checker
bind adc_result_format_ref_select adc_fmt_checker u_adc_fmt_checker (.pclk, .presetn, .psel,
    .penable, .pwrite, .paddr, .prdata, .pready, .pslverr, .conv_busy, .conv_done,
    .active_ref_select, .active_channel, .external_reference_pin_en,
    .analog_supply_reference_en, .internal_ref_power);
`default_nettype wire

//--- bench/adc_result_format_ref_select_test.sv
// Register-level tests of the result format and input select block
`timescale 1ns/1ps
`default_nettype none
module adc_result_format_ref_select_test;
    import adc_fmt_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, vector_ack, start, err;
    logic pready, pslverr, conv_busy, conv_done, irq, diff_mode, amplifier_input_short;
    logic external_reference_pin_en, analog_supply_reference_en, internal_ref_power;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0] pstrb, active_channel, single_input_index;
    logic [9:0] conv_value, code;
    logic [1:0] active_ref_select;
    route_t channel_route, er;
    int failures, n_tests, i;
    logic [9:0] diffs [5] = '{10'h1ff, 10'h000, 10'h3ff, 10'h200, 10'h270};
    adc_result_format_ref_select u_adc_result_format_ref_select (.pclk, .presetn, .psel,
        .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .conv_busy,
        .conv_done, .conv_value, .vector_ack, .active_ref_select, .active_channel,
        .channel_route, .single_input_index, .external_reference_pin_en,
        .analog_supply_reference_en, .internal_ref_power, .amplifier_input_short,
        .diff_mode, .irq);
    adc_core_model u_adc_core_model (.pclk, .presetn, .start, .code, .conv_busy,
        .conv_done, .conv_value);
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    task report_and_stop;
        $display("checks %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // Called just after an edge; holds the request until pready is seen high
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 100);
        chk(pready, 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // Idle edge, so the next setup never re-drives psel in this time step
        @(posedge pclk);
    endtask
    task rchk(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(rd, e);
    endtask
    // Low first, then high, as the lock pairing requires
    task res_chk(input logic [9:0] r, input logic l);
        logic [15:0] v;
        v = l ? {r, 6'h0} : {6'h0, r};
        rchk(OFF_RESULT_LOW, {24'h0, v[7:0]});
        rchk(OFF_RESULT_HIGH, {24'h0, v[15:8]});
    endtask
    task wait_done;
        int k;
        k = 0;
        while (conv_done !== 1'b1 && k < 50) begin
            @(posedge pclk);
            k++;
        end
        chk(conv_done, 1'b1);
        @(posedge pclk);
    endtask
    task conv(input logic [9:0] c);
        start <= 1'b1;
        code <= c;
        @(posedge pclk);
        start <= 1'b0;
        wait_done();
    endtask
    initial begin
        repeat (20000) @(posedge pclk);
        failures++;
        report_and_stop();
    end
    initial begin
        presetn = 1'b0;
        {psel, penable, pwrite, vector_ack, start} = 5'h0;
        paddr = 12'h0;
        pwdata = 32'h0;
        pstrb = 4'hf;
        code = 10'h0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rchk(OFF_INPUT_SELECT, 32'h0);
        res_chk(10'h0, 1'b0);
        apb(1'b1, OFF_INPUT_SELECT, 32'hff);
        rchk(OFF_INPUT_SELECT, 32'hef);
        apb(1'b1, OFF_IRQ_ENABLE, 32'h1);
        apb(1'b1, OFF_INPUT_SELECT, 32'h0);
        conv(10'h3ff);
        chk(irq, 1'b1);
        res_chk(10'h3ff, 1'b0);
        apb(1'b1, OFF_INPUT_SELECT, 32'h20);
        res_chk(10'h3ff, 1'b1);
        rchk(OFF_IRQ_STATUS, 32'h1);
        rchk(OFF_CONTROL, 32'h1);
        apb(1'b1, OFF_IRQ_CLEAR, 32'h1);
        @(posedge pclk);
        chk(irq, 1'b0);
        rchk(OFF_CONTROL, 32'h0);
        conv(10'h155);
        vector_ack <= 1'b1;
        @(posedge pclk);
        vector_ack <= 1'b0;
        rchk(OFF_CONTROL, 32'h0);
        conv(10'h155);
        apb(1'b1, OFF_CONTROL, 32'h1);
        rchk(OFF_CONTROL, 32'h0);
        $display("test flags done");
        apb(1'b1, OFF_CONTROL, 32'h8);
        @(posedge pclk);
        chk(diff_mode, 1'b1);
        for (i = 0; i < 5; i++) begin
            conv(diffs[i]);
            res_chk(diffs[i], 1'b1);
            apb(1'b0, OFF_RESULT_HIGH, 32'h0);
            chk(rd[7], diffs[i][9]);
        end
        conv(10'h2aa);
        rchk(OFF_RESULT_LOW, 32'h80);
        conv(10'h155);
        rchk(OFF_RESULT_HIGH, 32'haa);
        res_chk(10'h2aa, 1'b1);
        $display("test results done");
        start <= 1'b1;
        @(posedge pclk);
        start <= 1'b0;
        apb(1'b1, OFF_INPUT_SELECT, 32'he0);
        @(posedge pclk);
        chk(active_ref_select, 2'b00);
        wait_done();
        chk(active_ref_select, 2'b11);
        chk(internal_ref_power, 1'b0);
        apb(1'b1, OFF_CONTROL, 32'h6);
        @(posedge pclk);
        chk(internal_ref_power, 1'b1);
        chk(amplifier_input_short, 1'b1);
        for (i = 0; i < 4; i++) begin
            apb(1'b1, OFF_INPUT_SELECT, 32'(i << 6));
            @(posedge pclk);
            chk(external_reference_pin_en, i == 0);
            chk(analog_supply_reference_en, i == 1);
            chk(internal_ref_power, i == 3);
        end
        for (i = 0; i < 16; i++) begin
            apb(1'b1, OFF_INPUT_SELECT, 32'(i));
            @(posedge pclk);
            er = i <= 10 ? ROUTE_SINGLE : i == 11 ? ROUTE_AMPLIFIER_CHANNEL_ZERO : i == 12 ? ROUTE_AMPLIFIER_CHANNEL_ONE :
                i == 13 ? ROUTE_NONE : i == 14 ? ROUTE_BANDGAP : ROUTE_GROUND;
            chk(channel_route, er);
            chk(active_channel, i[3:0]);
            chk(diff_mode, i == 11 || i == 12);
            if (i <= 10) chk(single_input_index, i[3:0]);
        end
        apb(1'b0, 12'h020, 32'h0);
        chk(err, 1'b1);
        chk(rd, 32'h0);
        apb(1'b1, 12'h020, 32'hff);
        rchk(OFF_INPUT_SELECT, 32'h0f);
        $display("test selects done");
        report_and_stop();
    end
endmodule // adc_result_format_ref_select_test
`default_nettype wire

//--- hw/adc_fmt_pkg.sv
// Constants and types for the converter result format and input select block
package adc_fmt_pkg;
    localparam int unsigned RESULT_W = 10;
    localparam int unsigned ADDR_W = 12;

    // Register byte offsets
    localparam logic [11:0] OFF_INPUT_SELECT = 12'h000;
    localparam logic [11:0] OFF_RESULT_LOW = 12'h004;
    localparam logic [11:0] OFF_RESULT_HIGH = 12'h008;
    localparam logic [11:0] OFF_CONTROL = 12'h00c;
    localparam logic [11:0] OFF_IRQ_STATUS = 12'h010;
    localparam logic [11:0] OFF_IRQ_ENABLE = 12'h014;
    localparam logic [11:0] OFF_IRQ_CLEAR = 12'h018;

    // Input select field positions
    localparam int unsigned REF_SEL_HI_POS = 7;
    localparam int unsigned REF_SEL_LO_POS = 6;
    localparam int unsigned LEFT_JUSTIFY_POS = 5;
    localparam int unsigned UNUSED_BIT_POS = 4;
    localparam logic [7:0] INPUT_SELECT_WMASK = 8'hef;
    localparam logic [7:0] INPUT_SELECT_RESET = 8'h00;

    // Control register bit positions
    localparam int unsigned CTRL_DONE_POS = 0;
    localparam int unsigned CTRL_SHORT_POS = 1;
    localparam int unsigned CTRL_ANALOG_EN_POS = 2;
    localparam int unsigned CTRL_DIFF_POS = 3;

    // Interrupt status bit positions
    localparam int unsigned IRQ_DONE_POS = 0;
    localparam int unsigned IRQ_W = 1;

    // Reference selection codes
    typedef enum logic [1:0] {
        REF_EXTERNAL_PIN = 2'b00,
        REF_ANALOG_SUPPLY = 2'b01,
        REF_RESERVED = 2'b10,
        REF_INTERNAL_256 = 2'b11
    } ref_sel_t;

    // Channel selection codes
    localparam logic [3:0] CHAN_SINGLE_LAST = 4'ha;
    localparam logic [3:0] CHAN_AMPLIFIER_CHANNEL_ZERO = 4'hb;
    localparam logic [3:0] CHAN_AMPLIFIER_CHANNEL_ONE = 4'hc;
    localparam logic [3:0] CHAN_RESERVED = 4'hd;
    localparam logic [3:0] CHAN_BANDGAP = 4'he;
    localparam logic [3:0] CHAN_GROUND = 4'hf;

    typedef enum logic [2:0] {
        ROUTE_SINGLE = 3'b000,
        ROUTE_AMPLIFIER_CHANNEL_ZERO = 3'b001,
        ROUTE_AMPLIFIER_CHANNEL_ONE = 3'b010,
        ROUTE_BANDGAP = 3'b011,
        ROUTE_GROUND = 3'b100,
        ROUTE_NONE = 3'b101
    } route_t;

    localparam logic [9:0] DIFF_POS_FULL = 10'h1ff;
    localparam logic [9:0] DIFF_NEG_FULL = 10'h200;
    localparam logic [9:0] RESULT_RESET = 10'h000;
endpackage

//--- hw/adc_result_format_ref_select.sv
// Converter result register pair, input select register and reference control
`timescale 1ns/1ps
`default_nettype none
//Contract
// - Finished value held in result registers
// - Single-ended code is unsigned ten bits
// - Differential code is two's complement ten bits
// - Top result bit is differential sign
// - Differential codes span 0x200 to 0x1ff
// - High register holds upper, low lower bits
// - Reference codes: pin, supply, reserved, internal
// - Reference field bits seven and six, reset zero
// - Reference change waits for conversion done
// - Internal reference powered when selected and analog enabled
// - Bit five selects left or right justify
// - Justify change remaps results immediately
// - Input short ties differential inputs together
// - Four-bit channel code decode
// - Low read blocks updates until high read
// - Done flag set on update, cleared by one; set here on every conv_done, also when a locked pair drops the value
module adc_result_format_ref_select
    import adc_fmt_pkg::*;
(
    input wire logic pclk,                               // System clock
    input wire logic presetn,                            // Async reset, active low
    input wire logic psel,                               // APB select
    input wire logic penable,                            // APB enable
    input wire logic pwrite,                             // APB direction
    input wire logic [adc_fmt_pkg::ADDR_W-1:0] paddr,    // APB byte address
    input wire logic [31:0] pwdata,                      // APB write data
    input wire logic [3:0] pstrb,                        // APB byte strobes
    output logic [31:0] prdata,                          // APB read data
    output logic pready,                                 // APB ready
    output logic pslverr,                                // APB error
    input wire logic conv_busy,                          // Core converting
    input wire logic conv_done,                          // Core finished, one pulse
    input wire logic [9:0] conv_value,                   // Core raw result
    input wire logic vector_ack,                         // Interrupt vector taken
    output logic [1:0] active_ref_select,                // Reference seen by the core
    output logic [3:0] active_channel,                   // Channel seen by the core
    output adc_fmt_pkg::route_t channel_route,           // Decoded input route
    output logic [3:0] single_input_index,               // Single input number
    output logic external_reference_pin_en,              // Pin reference path
    output logic analog_supply_reference_en,             // Supply reference path
    output logic internal_ref_power,                     // Internal reference power
    output logic amplifier_input_short,                  // Short differential inputs
    output logic diff_mode,                              // Differential result coding
    output logic irq                                     // Level interrupt
);
    typedef struct packed {
        logic [7:0] input_select;
        logic [1:0] ref_active;
        logic [3:0] chan_active;
        logic ref_pending;
        logic chan_pending;
        logic [9:0] result;
        logic locked;
        logic done_flag;
        logic short_ctrl;
        logic analog_en;
        logic diff_ctrl;
        logic [IRQ_W-1:0] irq_status;
        logic [IRQ_W-1:0] irq_enable;
        logic [31:0] rdata;
    } state_t;

    state_t cur;
    state_t next_cur;
    logic [7:0] high_view;
    logic [7:0] low_view;
    logic [3:0] chan_in;

    // Layout follows the live select bit, so a flip remaps at once
    result_justify u_justify (
        .value(cur.result),
        .left_justify(cur.input_select[LEFT_JUSTIFY_POS]),
        .high_byte(high_view),
        .low_byte(low_view)
    );

    logic setup;
    logic wr;
    logic rd;
    logic mapped;
    logic [7:0] wbyte;
    logic update_ok;
    logic done_clear;

    assign chan_in = cur.input_select[3:0];

    always_comb begin
        next_cur = cur;
        setup = psel && !penable;
        wr = psel && penable && pwrite;
        rd = psel && penable && !pwrite;
        wbyte = pstrb[0] ? pwdata[7:0] : cur.input_select;
        mapped = (paddr == OFF_INPUT_SELECT) || (paddr == OFF_RESULT_LOW) ||
                 (paddr == OFF_RESULT_HIGH) || (paddr == OFF_CONTROL) ||
                 (paddr == OFF_IRQ_STATUS) || (paddr == OFF_IRQ_ENABLE) ||
                 (paddr == OFF_IRQ_CLEAR);
        done_clear = 1'b0;

        // Software writes
        if (wr && pstrb[0]) begin
            unique case (paddr)
                OFF_INPUT_SELECT: begin
                    next_cur.input_select = wbyte & INPUT_SELECT_WMASK;
                    if (conv_busy) begin
                        next_cur.ref_pending = 1'b1;
                        next_cur.chan_pending = 1'b1;
                    end else begin
                        next_cur.ref_active = wbyte[REF_SEL_HI_POS:REF_SEL_LO_POS];
                        next_cur.chan_active = wbyte[3:0];
                    end
                end
                OFF_CONTROL: begin
                    done_clear = pwdata[CTRL_DONE_POS];
                    next_cur.short_ctrl = pwdata[CTRL_SHORT_POS];
                    next_cur.analog_en = pwdata[CTRL_ANALOG_EN_POS];
                    next_cur.diff_ctrl = pwdata[CTRL_DIFF_POS];
                end
                OFF_IRQ_ENABLE: next_cur.irq_enable = pwdata[IRQ_W-1:0];
                OFF_IRQ_CLEAR: begin
                    next_cur.irq_status = cur.irq_status & ~pwdata[IRQ_W-1:0];
                    done_clear = done_clear | pwdata[IRQ_DONE_POS];
                end
                default: begin
                end
            endcase
        end

        if (done_clear || vector_ack) begin
            next_cur.done_flag = 1'b0;
        end

        // Read lock: low read locks, high read releases
        if (rd && paddr == OFF_RESULT_LOW) begin
            next_cur.locked = 1'b1;
        end
        if (rd && paddr == OFF_RESULT_HIGH) begin
            next_cur.locked = 1'b0;
        end

        // Finished conversion; a locked pair drops the new value
        update_ok = conv_done && !cur.locked;
        if (update_ok) begin
            // Raw core code passes through; the coding differs only in meaning
            next_cur.result = conv_value;
        end
        if (conv_done) begin
            // Set beats a same-cycle clear
            next_cur.done_flag = 1'b1;
            next_cur.irq_status[IRQ_DONE_POS] = 1'b1;
            if (cur.ref_pending || (wr && paddr == OFF_INPUT_SELECT && pstrb[0])) begin
                next_cur.ref_active =
                    next_cur.input_select[REF_SEL_HI_POS:REF_SEL_LO_POS];
                next_cur.chan_active = next_cur.input_select[3:0];
            end
            next_cur.ref_pending = 1'b0;
            next_cur.chan_pending = 1'b0;
        end

        // Read data registered at setup, presented in the access cycle
        if (setup && !pwrite) begin
            unique case (paddr)
                OFF_INPUT_SELECT: next_cur.rdata = {24'h000000, cur.input_select};
                OFF_RESULT_LOW: next_cur.rdata = {24'h000000, low_view};
                OFF_RESULT_HIGH: next_cur.rdata = {24'h000000, high_view};
                OFF_CONTROL: next_cur.rdata = {28'h0000000, cur.diff_ctrl, cur.analog_en,
                                               cur.short_ctrl, cur.done_flag};
                OFF_IRQ_STATUS: next_cur.rdata = {31'h00000000, cur.irq_status};
                OFF_IRQ_ENABLE: next_cur.rdata = {31'h00000000, cur.irq_enable};
                default: next_cur.rdata = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cur <= '0;
            cur.input_select <= INPUT_SELECT_RESET;
            cur.result <= RESULT_RESET;
        end else begin
            cur <= next_cur;
        end
    end

    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped;
    assign prdata = cur.rdata;

    // Reference paths
    always_comb begin
        external_reference_pin_en = 1'b0;
        analog_supply_reference_en = 1'b0;
        internal_ref_power = 1'b0;
        unique case (ref_sel_t'(cur.ref_active))
            REF_EXTERNAL_PIN: external_reference_pin_en = 1'b1;
            REF_ANALOG_SUPPLY: analog_supply_reference_en = 1'b1;
            REF_RESERVED: begin
            end
            // Powered only while some analog function wants it
            REF_INTERNAL_256: internal_ref_power = cur.analog_en;
        endcase
    end

    // Channel decode
    always_comb begin
        single_input_index = 4'h0;
        if (cur.chan_active <= CHAN_SINGLE_LAST) begin
            channel_route = ROUTE_SINGLE;
            single_input_index = cur.chan_active;
        end else if (cur.chan_active == CHAN_AMPLIFIER_CHANNEL_ZERO) begin
            channel_route = ROUTE_AMPLIFIER_CHANNEL_ZERO;
        end else if (cur.chan_active == CHAN_AMPLIFIER_CHANNEL_ONE) begin
            channel_route = ROUTE_AMPLIFIER_CHANNEL_ONE;
        end else if (cur.chan_active == CHAN_BANDGAP) begin
            channel_route = ROUTE_BANDGAP;
        end else if (cur.chan_active == CHAN_GROUND) begin
            channel_route = ROUTE_GROUND;
        end else begin
            channel_route = ROUTE_NONE;
        end
    end

    assign active_ref_select = cur.ref_active;
    assign active_channel = cur.chan_active;
    assign amplifier_input_short = cur.short_ctrl;
    // Differential codes from the core already span 0x200..0x1ff
    assign diff_mode = cur.diff_ctrl || channel_route == ROUTE_AMPLIFIER_CHANNEL_ZERO ||
                       channel_route == ROUTE_AMPLIFIER_CHANNEL_ONE;
    assign irq = |(cur.irq_status & cur.irq_enable);

    logic unused_ok;
    assign unused_ok = &{1'b0, chan_in, cur.chan_pending, pstrb[3:1], pwdata[31:8]};
endmodule // adc_result_format_ref_select
`default_nettype wire

//--- hw/result_justify.sv
// Maps a 10-bit result onto the high and low result register pair
`timescale 1ns/1ps
`default_nettype none
module result_justify (
    input wire logic [9:0] value,   // Held conversion value
    input wire logic left_justify,  // Layout select
    output logic [7:0] high_byte,   // High result register view
    output logic [7:0] low_byte     // Low result register view
);
    always_comb begin
        if (left_justify) begin
            high_byte = value[9:2];
            low_byte = {value[1:0], 6'h00};
        end else begin
            high_byte = {6'h00, value[9:8]};
            low_byte = value[7:0];
        end
    end
endmodule // result_justify
`default_nettype wire
